// File: core/cci_pkg.sv
// Summary of operation
// - select bit 1: AND all unmasked flags
// - select bit 0: OR any unmasked flag
// - enable bit 0 resets 0, pins quiet
// - enable 0 freezes flags against source edges
// - live register always shows raw sources
// - secondary rise bit 7, fall bit 6
// - primary rise bit 5, fall bit 4
// - per-pin open-drain select bits 1 and 0
// - polarity 1 rising, 0 falling sets flag
// - mask bit 1 removes source from pins and comb-rise event; its edges still set the flag-set event
package cci_pkg;
    localparam int NUM_SRC = 8;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;

    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_IRQ_MASK = 8'h0e;
    localparam logic [7:0] IDX_IRQ_POL = 8'h0f;
    localparam logic [7:0] IDX_IRQ_FLAG = 8'h10;
    localparam logic [7:0] IDX_INT_CTRL = 8'h11;
    localparam logic [7:0] IDX_SLEW_STS = 8'h12;
    localparam logic [7:0] IDX_PIN_CTRL = 8'h13;
    localparam logic [7:0] IDX_IRQ_LIVE = 8'h14;
    localparam logic [7:0] IDX_EVT_STS = 8'h15;
    localparam logic [7:0] IDX_EVT_CLR = 8'h16;
    localparam logic [7:0] IDX_EVT_EN = 8'h17;

    localparam int INTERRUPT_CONTROL_EN_BIT = 0;
    localparam int INTERRUPT_CONTROL_AND_BIT = 1;
    localparam logic [7:0] INTERRUPT_CONTROL_WMASK = 8'h03;
    localparam int PIN_OD_FIRST_BIT = 0;
    localparam int PIN_OD_SECOND_BIT = 1;
    localparam logic [7:0] PINCTL_WMASK = 8'h3f;
    localparam int SLEW_LSB = 4;
    localparam int SLEW_W = 4;
    localparam int SRC_PLL_ONE_LOCK_LOST = 7;

    localparam int EVT_FLAG_SET = 0;
    localparam int EVT_COMB_RISE = 1;
    localparam int EVT_W = 2;

    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } cci_apb_req_t;

    typedef struct packed {
        logic out;
        logic oe_n;
    } cci_pin_t;

    // field order matches the read layout, bit 7 down to bit 4
    typedef struct packed {
        logic secondary_rise_valid;
        logic secondary_fall_valid;
        logic primary_rise_valid;
        logic primary_fall_valid;
    } cci_slew_t;
endpackage

// File: core/cci_src_flags.sv
`timescale 1ns/1ps
module cci_src_flags (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [cci_pkg::NUM_SRC-1:0] src_async,
    input wire cci_pkg::cci_slew_t slew_async,
    input wire logic [cci_pkg::NUM_SRC-1:0] irq_edge_polarity,
    input wire logic irq_en,
    input wire logic clr_we,
    input wire logic [cci_pkg::NUM_SRC-1:0] clr_data,
    output logic [cci_pkg::NUM_SRC-1:0] irq_live_state,
    output cci_pkg::cci_slew_t slew_sync,
    output logic [cci_pkg::NUM_SRC-1:0] flags_q,
    output logic set_pulse
);
    import cci_pkg::*;

    logic [NUM_SRC-1:0] meta_q, meta_d, sync_q, sync_d, prev_q, prev_d, edge_hit, flags_d;
    logic [SLEW_W-1:0] smeta_q, smeta_d, ssync_q, ssync_d;

    // first stage feeds only the second stage
    genvar i;
    generate
        for (i = 0; i < NUM_SRC; i++) begin : g_edge
            assign edge_hit[i] = irq_edge_polarity[i] ? (sync_q[i] & ~prev_q[i])
                                                      : (~sync_q[i] & prev_q[i]);
        end
    endgenerate

    always_comb begin
        meta_d = src_async;
        sync_d = meta_q;
        prev_d = sync_q;
        smeta_d = slew_async;
        ssync_d = smeta_q;
        flags_d = flags_q;
        if (clr_we) begin
            flags_d = flags_q & clr_data;
        end
        // a set in the clearing cycle wins; edges are ignored while disabled
        if (irq_en) begin
            flags_d = flags_d | edge_hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= REG_RST;
            sync_q <= REG_RST;
            prev_q <= REG_RST;
            flags_q <= REG_RST;
            smeta_q <= '0;
            ssync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
            flags_q <= flags_d;
            smeta_q <= smeta_d;
            ssync_q <= ssync_d;
        end
    end

    assign irq_live_state = sync_q;
    assign slew_sync = cci_slew_t'(ssync_q);
    assign set_pulse = irq_en & (|edge_hit);
endmodule

// File: core/cci_top.sv
`timescale 1ns/1ps
module cci_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire cci_pkg::cci_apb_req_t apb_req,
    output logic [cci_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [cci_pkg::NUM_SRC-1:0] irq_src,
    input wire cci_pkg::cci_slew_t slew_in,
    output cci_pkg::cci_pin_t status_pin_first,
    output cci_pkg::cci_pin_t status_pin_second,
    output logic irq
);
    import cci_pkg::*;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        reg_hit = (addr == {2'b00, idx, 2'b00});
    endfunction

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
        addr_mapped = reg_hit(addr, IDX_IRQ_MASK) | reg_hit(addr, IDX_IRQ_POL)
                    | reg_hit(addr, IDX_IRQ_FLAG) | reg_hit(addr, IDX_INT_CTRL)
                    | reg_hit(addr, IDX_SLEW_STS) | reg_hit(addr, IDX_PIN_CTRL)
                    | reg_hit(addr, IDX_IRQ_LIVE) | reg_hit(addr, IDX_EVT_STS)
                    | reg_hit(addr, IDX_EVT_CLR) | reg_hit(addr, IDX_EVT_EN);
    endfunction

    logic [REG_W-1:0] mask_q, mask_d, pol_q, pol_d, interrupt_control_q, interrupt_control_d, pinctl_q, pinctl_d;
    logic [EVT_W-1:0] evt_sts_q, evt_sts_d, evt_en_q, evt_en_d;
    logic [DATA_W-1:0] prdata_q, prdata_d;
    logic comb_q, comb_d;
    cci_pin_t first_q, first_d, second_q, second_d;
    logic irq_q, irq_d;

    logic setup, access, wr, mapped;
    logic [REG_W-1:0] wbyte;
    logic [NUM_SRC-1:0] live, flags;
    cci_slew_t slew_s;
    logic flag_set;
    logic int_en, and_sel, any_unmasked, comb_raw;

    assign setup = apb_req.psel & ~apb_req.penable;
    assign access = apb_req.psel & apb_req.penable;
    assign mapped = addr_mapped(apb_req.paddr);
    assign wr = access & apb_req.pwrite & mapped;
    assign wbyte = apb_req.pwdata[REG_W-1:0];
    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    assign int_en = interrupt_control_q[INTERRUPT_CONTROL_EN_BIT];
    assign and_sel = interrupt_control_q[INTERRUPT_CONTROL_AND_BIT];

    cci_src_flags u_src (
        .pclk(pclk),
        .presetn(presetn),
        .src_async(irq_src),
        .slew_async(slew_in),
        .irq_edge_polarity(pol_q),
        .irq_en(int_en),
        .clr_we(wr & reg_hit(apb_req.paddr, IDX_IRQ_FLAG)),
        .clr_data(wbyte),
        .irq_live_state(live),
        .slew_sync(slew_s),
        .flags_q(flags),
        .set_pulse(flag_set)
    );

    // with every source masked, AND mode stays low rather than going true vacuously
    assign any_unmasked = |(~mask_q);
    always_comb begin
        if (and_sel) begin
            comb_raw = any_unmasked & (&(flags | mask_q));
        end else begin
            comb_raw = |(flags & ~mask_q);
        end
    end

    always_comb begin
        mask_d = mask_q;
        pol_d = pol_q;
        interrupt_control_d = interrupt_control_q;
        pinctl_d = pinctl_q;
        evt_en_d = evt_en_q;
        if (wr) begin
            if (reg_hit(apb_req.paddr, IDX_IRQ_MASK)) begin
                mask_d = wbyte;
            end
            if (reg_hit(apb_req.paddr, IDX_IRQ_POL)) begin
                pol_d = wbyte;
            end
            if (reg_hit(apb_req.paddr, IDX_INT_CTRL)) begin
                interrupt_control_d = wbyte & INTERRUPT_CONTROL_WMASK;
            end
            if (reg_hit(apb_req.paddr, IDX_PIN_CTRL)) begin
                pinctl_d = wbyte & PINCTL_WMASK;
            end
            if (reg_hit(apb_req.paddr, IDX_EVT_EN)) begin
                evt_en_d = wbyte[EVT_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= REG_RST;
            pol_q <= REG_RST;
            interrupt_control_q <= REG_RST;
            pinctl_q <= REG_RST;
            evt_en_q <= '0;
        end else begin
            mask_q <= mask_d;
            pol_q <= pol_d;
            interrupt_control_q <= interrupt_control_d;
            pinctl_q <= pinctl_d;
            evt_en_q <= evt_en_d;
        end
    end

    always_comb begin
        prdata_d = prdata_q;
        if (setup) begin
            prdata_d = RDATA_RST;
            if (reg_hit(apb_req.paddr, IDX_IRQ_MASK)) begin
                prdata_d[REG_W-1:0] = mask_q;
            end
            if (reg_hit(apb_req.paddr, IDX_IRQ_POL)) begin
                prdata_d[REG_W-1:0] = pol_q;
            end
            if (reg_hit(apb_req.paddr, IDX_IRQ_FLAG)) begin
                prdata_d[REG_W-1:0] = flags;
            end
            if (reg_hit(apb_req.paddr, IDX_INT_CTRL)) begin
                prdata_d[REG_W-1:0] = interrupt_control_q;
            end
            if (reg_hit(apb_req.paddr, IDX_SLEW_STS)) begin
                prdata_d[SLEW_LSB +: SLEW_W] = slew_s;
            end
            if (reg_hit(apb_req.paddr, IDX_PIN_CTRL)) begin
                prdata_d[REG_W-1:0] = pinctl_q;
            end
            if (reg_hit(apb_req.paddr, IDX_IRQ_LIVE)) begin
                prdata_d[NUM_SRC-1:0] = live;
            end
            if (reg_hit(apb_req.paddr, IDX_EVT_STS)) begin
                prdata_d[EVT_W-1:0] = evt_sts_q;
            end
            if (reg_hit(apb_req.paddr, IDX_EVT_EN)) begin
                prdata_d[EVT_W-1:0] = evt_en_q;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= RDATA_RST;
        end else begin
            prdata_q <= prdata_d;
        end
    end
    assign prdata = prdata_q;

    // pin stage: registered so the pads never see decode glitches
    always_comb begin
        comb_d = comb_raw & int_en;
        first_d.out = comb_d;
        first_d.oe_n = 1'b0;
        second_d.out = comb_d;
        second_d.oe_n = 1'b0;
        // open-drain pulls low while asserted and floats otherwise
        if (pinctl_q[PIN_OD_FIRST_BIT]) begin
            first_d.out = 1'b0;
            first_d.oe_n = ~comb_d;
        end
        if (pinctl_q[PIN_OD_SECOND_BIT]) begin
            second_d.out = 1'b0;
            second_d.oe_n = ~comb_d;
        end
    end

    // local event bits: set wins over a clear in the same cycle
    always_comb begin
        evt_sts_d = evt_sts_q;
        if (wr && reg_hit(apb_req.paddr, IDX_EVT_CLR)) begin
            evt_sts_d = evt_sts_q & ~wbyte[EVT_W-1:0];
        end
        evt_sts_d[EVT_FLAG_SET] = evt_sts_d[EVT_FLAG_SET] | flag_set;
        evt_sts_d[EVT_COMB_RISE] = evt_sts_d[EVT_COMB_RISE] | (comb_d & ~comb_q);
        irq_d = |(evt_sts_d & evt_en_d);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comb_q <= 1'b0;
            first_q <= '0;
            second_q <= '0;
            evt_sts_q <= '0;
            irq_q <= 1'b0;
        end else begin
            comb_q <= comb_d;
            first_q <= first_d;
            second_q <= second_d;
            evt_sts_q <= evt_sts_d;
            irq_q <= irq_d;
        end
    end

    assign status_pin_first = first_q;
    assign status_pin_second = second_q;
    assign irq = irq_q;

    a_and_combine: assert property (
        @(posedge pclk) disable iff (!presetn)
        (int_en && and_sel && !pinctl_q[PIN_OD_FIRST_BIT] && any_unmasked
         && ((flags | mask_q) == 8'hff) && $stable(interrupt_control_q) && $stable(pinctl_q))
        |=> status_pin_first.out)
        else $error("and mode did not assert with all unmasked flags set");

    a_and_partial: assert property (
        @(posedge pclk) disable iff (!presetn)
        (and_sel && ((flags | mask_q) != 8'hff)) |=> !comb_q)
        else $error("and mode asserted with an unmasked flag clear");

    a_or_combine: assert property (
        @(posedge pclk) disable iff (!presetn)
        (int_en && !and_sel && |(flags & ~mask_q)) |=> comb_q)
        else $error("or mode missed an unmasked flag");

    a_disabled_quiet: assert property (
        @(posedge pclk) disable iff (!presetn)
        !int_en |=> (!status_pin_first.out && !status_pin_second.out && !comb_q))
        else $error("status pin signalled while disabled");

    a_flags_frozen: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!int_en && !(wr && reg_hit(apb_req.paddr, IDX_IRQ_FLAG))) |=> $stable(flags))
        else $error("flags changed while disabled");

    a_live_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && reg_hit(apb_req.paddr, IDX_IRQ_LIVE))
        |=> (prdata[NUM_SRC-1:0] == $past(live)))
        else $error("live register read mismatch");

    a_slew_layout: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && reg_hit(apb_req.paddr, IDX_SLEW_STS))
        |=> (prdata[REG_W-1:0] == {$past(slew_s), 4'h0}))
        else $error("slew status bits misplaced");

    a_open_drain: assert property (
        @(posedge pclk) disable iff (!presetn)
        pinctl_q[PIN_OD_SECOND_BIT] && $stable(pinctl_q)
        |-> (!status_pin_second.out && (status_pin_second.oe_n == !comb_q)))
        else $error("second pin not open drain");

    a_edge_sets: assert property (
        @(posedge pclk) disable iff (!presetn)
        (int_en && pol_q[SRC_PLL_ONE_LOCK_LOST] && $rose(live[SRC_PLL_ONE_LOCK_LOST]))
        |=> flags[SRC_PLL_ONE_LOCK_LOST])
        else $error("rising edge did not set the lock lost flag");

    a_mask_blocks: assert property (
        @(posedge pclk) disable iff (!presetn)
        (mask_q == 8'hff) |=> !comb_q)
        else $error("fully masked sources raised the interrupt");
endmodule

// File: verif/cci_host_model.sv
`timescale 1ns/1ps
module cci_host_model
    import cci_pkg::*;
(
    input wire cci_pkg::cci_pin_t status_pin_first,
    input wire cci_pkg::cci_pin_t status_pin_second,
    output logic level_first,
    output logic level_second
);
    // host side has a pull-up on each status line, so a released pin reads high
    always_comb begin
        level_first = status_pin_first.oe_n ? 1'b1 : status_pin_first.out;
        level_second = status_pin_second.oe_n ? 1'b1 : status_pin_second.out;
    end
endmodule

// File: verif/cci_top_tb.sv
`timescale 1ns/1ps
module cci_top_tb;
    import cci_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    cci_apb_req_t apb_req = '0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [NUM_SRC-1:0] irq_src = 8'h00;
    cci_slew_t slew_in = '0;
    cci_pin_t pin_a;
    cci_pin_t pin_b;
    logic level_a;
    logic level_b;
    int errors = 0;
    int cmp_count = 0;

    always #2 pclk = ~pclk;

    cci_top dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq_src(irq_src), .slew_in(slew_in),
        .status_pin_first(pin_a), .status_pin_second(pin_b), .irq(irq));
    cci_host_model host (.status_pin_first(pin_a), .status_pin_second(pin_b),
        .level_first(level_a), .level_second(level_b));

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // entered right after a rising edge; leaves one idle edge so drives never collide
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr;
        apb_req.paddr <= {2'h0, idx, 2'h0};
        apb_req.pwdata <= wd;
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            errors++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, {24'h00_0000, d}, r, e);
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 32'h0000_0000, r, e);
        check(r, {24'h00_0000, exp});
    endtask

    // lets source sync, flag and pin stages settle, then samples off the edge
    task automatic pins(input logic i, input logic [1:0] a, input logic [1:0] b);
        repeat (6) @(posedge pclk);
        #1;
        check({27'h000_0000, irq, pin_a, pin_b}, {27'h000_0000, i, a, b});
        @(posedge pclk);
    endtask

    task automatic t_reset;
        logic [31:0] r;
        logic e;
        rchk(IDX_INT_CTRL, 8'h00);
        rchk(IDX_SLEW_STS, 8'h00);
        rchk(IDX_PIN_CTRL, 8'h00);
        rchk(IDX_IRQ_FLAG, 8'h00);
        apb(1'b0, 8'h3f, 32'h0000_0000, r, e);
        check({31'h0000_0000, e}, 32'h0000_0001);
    endtask

    task automatic t_live;
        wr(IDX_IRQ_POL, 8'hff);
        irq_src <= 8'h81;
        pins(1'h0, 2'h0, 2'h0);
        rchk(IDX_IRQ_LIVE, 8'h81);
        rchk(IDX_IRQ_FLAG, 8'h00);
        irq_src <= 8'h00;
        pins(1'h0, 2'h0, 2'h0);
    endtask

    task automatic t_edges;
        wr(IDX_INT_CTRL, 8'h01);
        wr(IDX_IRQ_POL, 8'h80);
        irq_src <= 8'h80;
        pins(1'h0, 2'h2, 2'h2);
        rchk(IDX_IRQ_FLAG, 8'h80);
        irq_src <= 8'h81;
        pins(1'h0, 2'h2, 2'h2);
        rchk(IDX_IRQ_FLAG, 8'h80);
        irq_src <= 8'h80;
        pins(1'h0, 2'h2, 2'h2);
        rchk(IDX_IRQ_FLAG, 8'h81);
        wr(IDX_IRQ_FLAG, 8'h01);
        rchk(IDX_IRQ_FLAG, 8'h01);
    endtask

    task automatic t_combine;
        wr(IDX_INT_CTRL, 8'h03);
        pins(1'h0, 2'h0, 2'h0);
        wr(IDX_IRQ_MASK, 8'hfe);
        pins(1'h0, 2'h2, 2'h2);
        wr(IDX_IRQ_MASK, 8'hff);
        pins(1'h0, 2'h0, 2'h0);
        wr(IDX_INT_CTRL, 8'h01);
        pins(1'h0, 2'h0, 2'h0);
        wr(IDX_IRQ_MASK, 8'h00);
        pins(1'h0, 2'h2, 2'h2);
        wr(IDX_INT_CTRL, 8'h00);
        pins(1'h0, 2'h0, 2'h0);
        wr(IDX_INT_CTRL, 8'hfd);
        rchk(IDX_INT_CTRL, 8'h01);
    endtask

    task automatic t_open_drain;
        wr(IDX_PIN_CTRL, 8'hff);
        rchk(IDX_PIN_CTRL, 8'h3f);
        wr(IDX_PIN_CTRL, 8'h01);
        pins(1'h0, 2'h0, 2'h2);
        check({30'h0000_0000, level_a, level_b}, 32'h0000_0001);
        wr(IDX_IRQ_FLAG, 8'h00);
        pins(1'h0, 2'h1, 2'h0);
        check({30'h0000_0000, level_a, level_b}, 32'h0000_0002);
        wr(IDX_PIN_CTRL, 8'h02);
        pins(1'h0, 2'h0, 2'h1);
        check({30'h0000_0000, level_a, level_b}, 32'h0000_0001);
        wr(IDX_PIN_CTRL, 8'h00);
    endtask

    task automatic t_events;
        wr(IDX_EVT_EN, 8'h01);
        wr(IDX_EVT_CLR, 8'h03);
        irq_src <= 8'h00;
        pins(1'h0, 2'h0, 2'h0);
        irq_src <= 8'h80;
        pins(1'h1, 2'h2, 2'h2);
        rchk(IDX_EVT_STS, 8'h03);
        wr(IDX_EVT_CLR, 8'h01);
        pins(1'h0, 2'h2, 2'h2);
        rchk(IDX_EVT_STS, 8'h02);
        wr(IDX_EVT_EN, 8'h02);
        pins(1'h1, 2'h2, 2'h2);
        wr(IDX_EVT_CLR, 8'h02);
        pins(1'h0, 2'h2, 2'h2);
    endtask

    task automatic t_slew;
        slew_in <= 4'h9;
        pins(1'h0, 2'h2, 2'h2);
        rchk(IDX_SLEW_STS, 8'h90);
        slew_in <= 4'h6;
        pins(1'h0, 2'h2, 2'h2);
        rchk(IDX_SLEW_STS, 8'h60);
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_live();
        t_edges();
        t_combine();
        t_open_drain();
        t_events();
        t_slew();
        stop_test();
    end

    // cuts a hang short; the whole sequence needs well under this many cycles
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        stop_test();
    end
endmodule
